/* hw/dbt_dual_byte_timer.sv */
// What this block does
// R1: mode 0: two independent half-rate 8-bit timers
// R2: mode 0 outputs toggle once per counter period
// R3: mode 1: two 8-bit PWMs on cycle clock
// R4: mode 2: cascaded 16-bit, low keeps own interrupt
// R5: mode 2 outputs toggle per low, full period
// R6: mode 3: low byte runs as PWM
// R7: mode 3 high output toggles per full period
// R8: period raises request when its enable set
// R9: stopped counter holds its output pin high
// R10: running with match all ones forces output low
// R11: low prescaler runs only while low_run set
// R12: low prescaler input: half-rate/events or cycle
// R13: pin select chooses external events over half-rate
// R14: software never selects event pin in PWM
// R15: prescale enable and code give power-of-two divide
// R16: prescaler cleared when stopped or counter resets
// R17: cascade advances high per low period; separate matches
// R18: match buffer tracks data stopped, reloads at zero
// R19: counters clear when stopped or, outside PWM, on match
// R20: PWM output clears on overflow, sets on match
// R21: external edges synchronised before use
`timescale 1ns/1ps
`default_nettype none

module dbt_dual_byte_timer
    import dbt_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // external event pins
    input wire logic i_ext_irq_pin_a,
    input wire logic i_ext_irq_pin_b,
    // outputs
    output logic o_low_output_pin,
    output logic o_high_output_pin,
    output logic o_low_irq_req,
    output logic o_high_irq_req
);

    logic [7:0] timer_control_reg;
    logic [7:0] prescale_select_reg;
    logic [7:0] low_match_data;
    logic [7:0] high_match_data;
    logic [1:0] ext_pin_select_reg;

    logic [7:0] low_counter;
    logic [7:0] high_counter;
    logic [7:0] low_buf;
    logic [7:0] high_buf;
    logic [7:0] low_pre;
    logic [7:0] high_pre;
    logic half_phase;
    logic low_out;
    logic high_out;

    logic [DBT_EXT_PINS-1:0] sync1;
    logic [DBT_EXT_PINS-1:0] sync2;
    logic [DBT_EXT_PINS-1:0] sync3;
    logic [DBT_EXT_PINS-1:0] pin_level;
    logic [DBT_EXT_PINS-1:0] pin_rise;

    logic high_run;
    logic low_run;
    logic cascade_select;
    logic pwm_select;
    logic low_irq_enable;
    logic high_irq_enable;
    logic low_prescale_enable;
    logic high_prescale_enable;
    logic [2:0] low_prescale_code;
    logic [2:0] high_prescale_code;

    dbt_mode_e mode;
    logic half_tick;
    logic ext_event;
    logic ext_selected;
    logic low_in_tick;
    logic high_in_tick;
    logic [7:0] low_last;
    logic [7:0] high_last;
    logic low_clk;
    logic high_clk;
    logic low_match;
    logic high_match;
    logic low_ovf;
    logic high_ovf;
    logic low_pwm;
    logic high_pwm;
    logic low_period;
    logic high_period;
    logic next_low_pin;
    logic next_high_pin;

    assign high_run = timer_control_reg[DBT_CTL_HIGH_RUN];
    assign low_run = timer_control_reg[DBT_CTL_LOW_RUN];
    assign cascade_select = timer_control_reg[DBT_CTL_CASCADE];
    assign pwm_select = timer_control_reg[DBT_CTL_PWM];
    assign high_irq_enable = timer_control_reg[DBT_CTL_HIGH_IRQ_EN];
    assign low_irq_enable = timer_control_reg[DBT_CTL_LOW_IRQ_EN];
    assign high_prescale_enable = prescale_select_reg[DBT_PRE_HIGH_EN];
    assign low_prescale_enable = prescale_select_reg[DBT_PRE_LOW_EN];
    assign high_prescale_code =
        prescale_select_reg[DBT_PRE_HIGH_CODE +: 3];
    assign low_prescale_code = prescale_select_reg[DBT_PRE_LOW_CODE +: 3];

    always_comb begin
        case ({cascade_select, pwm_select})
            2'b00: mode = DBT_MODE0;
            2'b01: mode = DBT_MODE1;
            2'b10: mode = DBT_MODE2;
            2'b11: mode = DBT_MODE3;
            default: mode = DBT_MODE0;
        endcase
    end

    // register writes
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer_control_reg <= DBT_RST_CONTROL;
            prescale_select_reg <= DBT_RST_PRESCALE;
            low_match_data <= DBT_RST_MATCH;
            high_match_data <= DBT_RST_MATCH;
            ext_pin_select_reg <= DBT_RST_PIN_SELECT;
        end else begin
            if (i_wr) begin
                case (i_addr)
                    DBT_ADDR_CONTROL: begin
                        timer_control_reg[7:4] <= i_wdata[7:4];
                        timer_control_reg[DBT_CTL_HIGH_IRQ_EN] <=
                            i_wdata[DBT_CTL_HIGH_IRQ_EN];
                        timer_control_reg[DBT_CTL_LOW_IRQ_EN] <=
                            i_wdata[DBT_CTL_LOW_IRQ_EN];
                    end
                    DBT_ADDR_PRESCALE: prescale_select_reg <= i_wdata;
                    DBT_ADDR_LOW_MATCH: low_match_data <= i_wdata;
                    DBT_ADDR_HIGH_MATCH: high_match_data <= i_wdata;
                    DBT_ADDR_PIN_SELECT:
                        ext_pin_select_reg <= i_wdata[1:0];
                    default: ;
                endcase
            end
            // a period in the clearing cycle keeps its flag set
            timer_control_reg[DBT_CTL_LOW_FLAG] <= low_period |
                (timer_control_reg[DBT_CTL_LOW_FLAG] &
                 !(i_wr && i_addr == DBT_ADDR_CONTROL &&
                   !i_wdata[DBT_CTL_LOW_FLAG]));
            timer_control_reg[DBT_CTL_HIGH_FLAG] <= high_period |
                (timer_control_reg[DBT_CTL_HIGH_FLAG] &
                 !(i_wr && i_addr == DBT_ADDR_CONTROL &&
                   !i_wdata[DBT_CTL_HIGH_FLAG]));
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= DBT_ZERO;
        end else if (i_rd) begin
            case (i_addr)
                DBT_ADDR_CONTROL: o_rdata <= timer_control_reg;
                DBT_ADDR_PRESCALE: o_rdata <= prescale_select_reg;
                DBT_ADDR_LOW_COUNT: o_rdata <= low_counter;
                DBT_ADDR_HIGH_COUNT: o_rdata <= high_counter;
                DBT_ADDR_LOW_MATCH: o_rdata <= low_match_data;
                DBT_ADDR_HIGH_MATCH: o_rdata <= high_match_data;
                DBT_ADDR_PIN_SELECT: o_rdata <= {6'h00, ext_pin_select_reg};
                default: o_rdata <= DBT_ZERO;
            endcase
        end else begin
            o_rdata <= DBT_ZERO;
        end
    end

    // three-stage synchroniser; only stages two and three are compared
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pin_level <= '0;
        end else begin
            sync1 <= {i_ext_irq_pin_b, i_ext_irq_pin_a}; // [R21]
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < DBT_EXT_PINS; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin_level[i] <= sync3[i];
                end
            end
        end
    end

    // rising edge counts once both late stages agree
    assign pin_rise = sync3 & (sync2 ~^ sync3) & ~pin_level; // [R21]
    assign ext_selected = |ext_pin_select_reg; // [R13]
    assign ext_event =
        (ext_pin_select_reg[DBT_SEL_PIN_A] & pin_rise[0]) |
        (ext_pin_select_reg[DBT_SEL_PIN_B] & pin_rise[1]); // [R13]

    // free-running half-rate enable
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            half_phase <= 1'b0;
        end else begin
            half_phase <= !half_phase;
        end
    end

    assign half_tick = half_phase; // [R1]

    // pin events in PWM modes are a software error and are ignored
    always_comb begin
        case (mode)
            DBT_MODE1, DBT_MODE3: low_in_tick = 1'b1; // [R12] [R14]
            default: low_in_tick = ext_selected ? ext_event
                                                : half_tick; // [R12]
        endcase
    end

    always_comb begin
        case (mode)
            DBT_MODE0: high_in_tick = half_tick; // [R1]
            DBT_MODE1: high_in_tick = 1'b1; // [R3]
            DBT_MODE2: high_in_tick = low_match; // [R4] [R17]
            DBT_MODE3: high_in_tick = low_ovf; // [R7] [R17]
            default: high_in_tick = 1'b0;
        endcase
    end

    assign low_last = dbt_presc_last(low_prescale_enable,
                                     low_prescale_code); // [R15]
    assign high_last = dbt_presc_last(high_prescale_enable,
                                      high_prescale_code); // [R15]

    // prescalers wrap in step with their counter, so a counter reset
    // always lands on a cleared prescaler
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_pre <= DBT_ZERO;
        end else if (!low_run) begin
            low_pre <= DBT_ZERO; // [R11] [R16]
        end else if (low_in_tick) begin
            low_pre <= (low_pre == low_last) ? DBT_ZERO
                                             : low_pre + DBT_ONE; // [R16]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            high_pre <= DBT_ZERO;
        end else if (!high_run) begin
            high_pre <= DBT_ZERO;
        end else if (high_in_tick) begin
            high_pre <= (high_pre == high_last) ? DBT_ZERO
                                                : high_pre + DBT_ONE;
        end
    end

    assign low_clk = low_run & low_in_tick & (low_pre == low_last);
    assign high_clk = high_run & high_in_tick & (high_pre == high_last);
    assign low_match = low_clk & (low_counter == low_buf); // [R17]
    assign high_match = high_clk & (high_counter == high_buf); // [R17]
    assign low_ovf = low_clk & (low_counter == DBT_ALL_ONES);
    assign high_ovf = high_clk & (high_counter == DBT_ALL_ONES);
    assign low_pwm = pwm_select; // [R3] [R6]
    assign high_pwm = pwm_select & !cascade_select; // [R3]

    // a counter period ends on overflow in PWM, else on match
    assign low_period = low_pwm ? low_ovf : low_match; // [R4] [R8]
    assign high_period = high_pwm ? high_ovf : high_match; // [R8]

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_counter <= DBT_RST_COUNT;
        end else if (!low_run) begin
            low_counter <= DBT_ZERO; // [R19]
        end else if (low_clk) begin
            if (!low_pwm && low_counter == low_buf) begin
                low_counter <= DBT_ZERO; // [R19]
            end else begin
                low_counter <= low_counter + DBT_ONE;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            high_counter <= DBT_RST_COUNT;
        end else if (!high_run) begin
            high_counter <= DBT_ZERO; // [R19]
        end else if (high_clk) begin
            if (!high_pwm && high_counter == high_buf) begin
                high_counter <= DBT_ZERO; // [R19]
            end else begin
                high_counter <= high_counter + DBT_ONE;
            end
        end
    end

    // new match data takes effect while stopped, else only at a period boundary
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_buf <= DBT_RST_MATCH;
            high_buf <= DBT_RST_MATCH;
        end else begin
            if (!low_run || low_counter == DBT_ZERO) begin
                low_buf <= low_match_data; // [R18]
            end
            if (!high_run || high_counter == DBT_ZERO) begin
                high_buf <= high_match_data; // [R18]
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_out <= 1'b1;
        end else if (!low_run) begin
            low_out <= 1'b1;
        end else if (low_pwm) begin
            if (low_ovf) begin
                low_out <= 1'b0; // [R20]
            end else if (low_match) begin
                low_out <= 1'b1; // [R20]
            end
        end else if (low_match) begin
            low_out <= !low_out; // [R2] [R5]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            high_out <= 1'b1;
        end else if (!high_run) begin
            high_out <= 1'b1;
        end else if (high_pwm) begin
            if (high_ovf) begin
                high_out <= 1'b0; // [R20]
            end else if (high_match) begin
                high_out <= 1'b1; // [R20]
            end
        end else if (high_match) begin
            high_out <= !high_out; // [R2] [R5] [R7]
        end
    end

    always_comb begin
        if (!low_run) begin
            next_low_pin = 1'b1; // [R9]
        end else if (low_match_data == DBT_ALL_ONES) begin
            next_low_pin = 1'b0; // [R10]
        end else begin
            next_low_pin = low_out;
        end
        if (!high_run) begin
            next_high_pin = 1'b1; // [R9]
        end else if (high_match_data == DBT_ALL_ONES) begin
            next_high_pin = 1'b0; // [R10]
        end else begin
            next_high_pin = high_out;
        end
    end

    // pins are registered, so they trail the counter by one cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_low_output_pin <= 1'b1;
            o_high_output_pin <= 1'b1;
            o_low_irq_req <= 1'b0;
            o_high_irq_req <= 1'b0;
        end else begin
            o_low_output_pin <= next_low_pin;
            o_high_output_pin <= next_high_pin;
            o_low_irq_req <= timer_control_reg[DBT_CTL_LOW_FLAG] &
                             low_irq_enable; // [R8]
            o_high_irq_req <= timer_control_reg[DBT_CTL_HIGH_FLAG] &
                              high_irq_enable; // [R8]
        end
    end

endmodule

`default_nettype wire

/* hw/dbt_pkg.sv */
package dbt_pkg;

    // register byte addresses
    localparam logic [15:0] DBT_ADDR_CONTROL = 16'hfe18;
    localparam logic [15:0] DBT_ADDR_PRESCALE = 16'hfe19;
    localparam logic [15:0] DBT_ADDR_LOW_COUNT = 16'hfe1a;
    localparam logic [15:0] DBT_ADDR_HIGH_COUNT = 16'hfe1b;
    localparam logic [15:0] DBT_ADDR_LOW_MATCH = 16'hfe1c;
    localparam logic [15:0] DBT_ADDR_HIGH_MATCH = 16'hfe1d;
    localparam logic [15:0] DBT_ADDR_PIN_SELECT = 16'hfe1e;

    // timer_control_reg fields
    localparam int DBT_CTL_HIGH_RUN = 7;
    localparam int DBT_CTL_LOW_RUN = 6;
    localparam int DBT_CTL_CASCADE = 5;
    localparam int DBT_CTL_PWM = 4;
    localparam int DBT_CTL_HIGH_FLAG = 3;
    localparam int DBT_CTL_HIGH_IRQ_EN = 2;
    localparam int DBT_CTL_LOW_FLAG = 1;
    localparam int DBT_CTL_LOW_IRQ_EN = 0;

    // prescale_select_reg fields
    localparam int DBT_PRE_HIGH_EN = 7;
    localparam int DBT_PRE_HIGH_CODE = 4;
    localparam int DBT_PRE_LOW_EN = 3;
    localparam int DBT_PRE_LOW_CODE = 0;

    // ext_pin_select_reg fields
    localparam int DBT_SEL_PIN_A = 0;
    localparam int DBT_SEL_PIN_B = 1;
    localparam int DBT_EXT_PINS = 2;

    // values after reset
    localparam logic [7:0] DBT_RST_CONTROL = 8'h00;
    localparam logic [7:0] DBT_RST_PRESCALE = 8'h00;
    localparam logic [7:0] DBT_RST_MATCH = 8'h00;
    localparam logic [7:0] DBT_RST_COUNT = 8'h00;
    localparam logic [1:0] DBT_RST_PIN_SELECT = 2'h0;

    localparam logic [7:0] DBT_ALL_ONES = 8'hff;
    localparam logic [7:0] DBT_ZERO = 8'h00;
    localparam logic [7:0] DBT_ONE = 8'h01;

    typedef enum logic [3:0] {
        DBT_MODE0 = 4'b0001,
        DBT_MODE1 = 4'b0010,
        DBT_MODE2 = 4'b0100,
        DBT_MODE3 = 4'b1000
    } dbt_mode_e;

    // last prescaler count: 0 when disabled, 2^(code+1)-1 otherwise
    function automatic logic [7:0] dbt_presc_last(input logic en,
                                                  input logic [2:0] code);
        logic [8:0] n;
        n = 9'h002 << code;
        return en ? n[7:0] - DBT_ONE : DBT_ZERO;
    endfunction

endpackage

/* sim/dbt_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module dbt_chk
    import dbt_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // outputs
    input wire logic o_low_output_pin,
    input wire logic o_high_output_pin,
    input wire logic o_low_irq_req,
    input wire logic o_high_irq_req
);
    // shadows of the writable bits that need no hardware help
    logic [7:0] ctl;
    logic [7:0] lm;
    logic [7:0] hm;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl <= DBT_RST_CONTROL;
            lm <= DBT_RST_MATCH;
            hm <= DBT_RST_MATCH;
        end else if (i_wr) begin
            if (i_addr == DBT_ADDR_CONTROL) ctl <= i_wdata;
            if (i_addr == DBT_ADDR_LOW_MATCH) lm <= i_wdata;
            if (i_addr == DBT_ADDR_HIGH_MATCH) hm <= i_wdata;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    // three cycles cover the register stage and the pin stage
    sequence s_low_idle;
        !ctl[DBT_CTL_LOW_RUN] [*3];
    endsequence
    sequence s_high_idle;
        !ctl[DBT_CTL_HIGH_RUN] [*3];
    endsequence
    sequence s_low_ff;
        (ctl[DBT_CTL_LOW_RUN] && lm == DBT_ALL_ONES) [*3];
    endsequence
    sequence s_high_ff;
        (ctl[DBT_CTL_HIGH_RUN] && hm == DBT_ALL_ONES) [*3];
    endsequence

    a_low_stop_high: assert property (s_low_idle |-> o_low_output_pin)
        else $error("low pin not high while stopped");
    a_high_stop_high: assert property (
        s_high_idle |-> o_high_output_pin)
        else $error("high pin not high while stopped");
    a_low_ff_low: assert property (s_low_ff |-> !o_low_output_pin)
        else $error("low pin not forced low");
    a_high_ff_low: assert property (s_high_ff |-> !o_high_output_pin)
        else $error("high pin not forced low");
    a_low_irq_gate: assert property (
        !ctl[DBT_CTL_LOW_IRQ_EN] [*2] |-> !o_low_irq_req)
        else $error("low request while disabled");
    a_high_irq_gate: assert property (
        !ctl[DBT_CTL_HIGH_IRQ_EN] [*2] |-> !o_high_irq_req)
        else $error("high request while disabled");
    a_low_count_clear: assert property (
        s_low_idle ##0 (i_rd && i_addr == DBT_ADDR_LOW_COUNT)
        |=> o_rdata == DBT_ZERO)
        else $error("stopped low count not zero");
    a_high_count_clear: assert property (
        s_high_idle ##0 (i_rd && i_addr == DBT_ADDR_HIGH_COUNT)
        |=> o_rdata == DBT_ZERO)
        else $error("stopped high count not zero");
endmodule

bind dbt_dual_byte_timer dbt_chk u_chk (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_low_output_pin(o_low_output_pin),
    .o_high_output_pin(o_high_output_pin),
    .o_low_irq_req(o_low_irq_req),
    .o_high_irq_req(o_high_irq_req)
);

`default_nettype wire

/* sim/dbt_dual_byte_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module dbt_dual_byte_timer_tb;
    import dbt_pkg::*;
    logic clk, rst_n, wr, rd, fire_a, fire_b, pin_a, pin_b;
    logic lpin, hpin, lirq, hirq;
    logic [15:0] addr, low_edges;
    logic [7:0] wdata, rdata;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;

    dbt_dual_byte_timer DUT (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_ext_irq_pin_a(pin_a), .i_ext_irq_pin_b(pin_b),
        .o_low_output_pin(lpin), .o_high_output_pin(hpin),
        .o_low_irq_req(lirq), .o_high_irq_req(hirq));
    dbt_pin_model u_pins (.i_ref_clk(clk), .i_fire_a(fire_a),
        .i_fire_b(fire_b), .o_ext_irq_pin_a(pin_a),
        .o_ext_irq_pin_b(pin_b), .i_low_output_pin(lpin),
        .o_low_edges(low_edges));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // cycles until the chosen pin shows level v
    task automatic wait_lvl(input logic hi, input logic v, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((hi ? hpin : lpin) !== v && n < 3000);
    endtask

    task automatic low_time(input logic hi, output int n);
        wait_lvl(hi, 1'b1, n);
        wait_lvl(hi, 1'b0, n);
        wait_lvl(hi, 1'b1, n);
    endtask

    task automatic ev(input logic b);
        @(posedge clk);
        if (b) fire_b <= 1'b1;
        else fire_a <= 1'b1;
        @(posedge clk);
        fire_a <= 1'b0;
        fire_b <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    task automatic test_reset();
        logic [7:0] d;
        check("low pin", lpin, 1'b1);
        check("high pin", hpin, 1'b1);
        wr_reg(DBT_ADDR_LOW_COUNT, 8'h5a);
        for (int i = 0; i < 8; i++) begin
            rd_reg(DBT_ADDR_CONTROL + 16'(i), d);
            check("reset value", d, DBT_RST_COUNT);
        end
        wr_reg(DBT_ADDR_PRESCALE, 8'ha5);
        rd_reg(DBT_ADDR_PRESCALE, d);
        check("prescale rw", d, 8'ha5);
        wr_reg(DBT_ADDR_PRESCALE, DBT_RST_PRESCALE);
    endtask

    task automatic test_events();
        logic [15:0] e0;
        wr_reg(DBT_ADDR_PIN_SELECT, 8'h01);
        wr_reg(DBT_ADDR_PRESCALE, 8'h08);
        wr_reg(DBT_ADDR_CONTROL, 8'h40);
        e0 = low_edges;
        repeat (20) @(posedge clk);
        check("idle events", low_edges - e0, 16'h0000);
        // half a prescale count, then a stop that must clear it
        ev(1'b0);
        wr_reg(DBT_ADDR_CONTROL, 8'h00);
        wr_reg(DBT_ADDR_CONTROL, 8'h40);
        ev(1'b0);
        check("pre cleared", low_edges - e0, 16'h0000);
        wr_reg(DBT_ADDR_CONTROL, 8'h00);
        wr_reg(DBT_ADDR_PRESCALE, 8'h00);
        wr_reg(DBT_ADDR_LOW_MATCH, 8'h01);
        wr_reg(DBT_ADDR_CONTROL, 8'h40);
        repeat (4) ev(1'b0);
        check("events a", low_edges - e0, 16'h0002);
        wr_reg(DBT_ADDR_PIN_SELECT, 8'h02);
        ev(1'b1);
        // new match data mid-period must wait for the count to reach 0
        wr_reg(DBT_ADDR_LOW_MATCH, 8'h03);
        ev(1'b1);
        check("events b", low_edges - e0, 16'h0003);
        wr_reg(DBT_ADDR_CONTROL, 8'h00);
        wr_reg(DBT_ADDR_PIN_SELECT, 8'h00);
    endtask

    task automatic test_modes();
        logic [7:0] ctl [4] = '{8'hc5, 8'hd0, 8'he0, 8'hf0};
        logic [7:0] pre [4] = '{8'hf8, 8'h00, 8'h0a, 8'h00};
        logic [7:0] lm [4] = '{8'h03, 8'h0f, 8'h01, 8'h7f};
        logic [7:0] hm [4] = '{8'h00, 8'h3f, 8'h02, 8'h00};
        logic [15:0] lo [4] = '{16'd16, 16'd16, 16'd32, 16'd128};
        logic [15:0] hi [4] = '{16'd512, 16'd64, 16'd96, 16'd256};
        logic [7:0] d;
        int n;
        for (int i = 0; i < 4; i++) begin
            wr_reg(DBT_ADDR_CONTROL, 8'h00);
            wr_reg(DBT_ADDR_PRESCALE, pre[i]);
            wr_reg(DBT_ADDR_LOW_MATCH, lm[i]);
            wr_reg(DBT_ADDR_HIGH_MATCH, hm[i]);
            wr_reg(DBT_ADDR_CONTROL, ctl[i]);
            low_time(1'b0, n);
            check("low time", n[15:0], lo[i]);
            low_time(1'b1, n);
            check("high time", n[15:0], hi[i]);
            if (i == 0) begin
                check("low irq", lirq, 1'b1);
                check("high irq", hirq, 1'b1);
            end
        end
        rd_reg(DBT_ADDR_CONTROL, d);
        check("flags", d, 8'hfa);
        wr_reg(DBT_ADDR_CONTROL, 8'h05);
        repeat (3) @(negedge clk);
        check("irq clear", {lirq, hirq}, 2'b00);
    endtask

    task automatic test_fixed();
        wr_reg(DBT_ADDR_LOW_MATCH, DBT_ALL_ONES);
        wr_reg(DBT_ADDR_HIGH_MATCH, DBT_ALL_ONES);
        wr_reg(DBT_ADDR_CONTROL, 8'hc0);
        repeat (4) @(negedge clk);
        check("pins forced", {lpin, hpin}, 2'b00);
        repeat (600) @(negedge clk);
        check("pins held", {lpin, hpin}, 2'b00);
        wr_reg(DBT_ADDR_CONTROL, 8'h00);
        repeat (3) @(negedge clk);
        check("pins stopped", {lpin, hpin}, 2'b11);
    endtask

    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
        fire_a = 1'b0;
        fire_b = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        test_reset();
        test_events();
        test_modes();
        test_fixed();
        give_verdict();
    end
endmodule

`default_nettype wire

/* sim/dbt_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dbt_pin_model (
    // clock
    input wire logic i_ref_clk,
    // event requests
    input wire logic i_fire_a,
    input wire logic i_fire_b,
    // pins
    output logic o_ext_irq_pin_a,
    output logic o_ext_irq_pin_b,
    input wire logic i_low_output_pin,
    output logic [15:0] o_low_edges
);
    logic [3:0] cnt_a = 4'h0;
    logic [3:0] cnt_b = 4'h0;
    logic [15:0] edge_cnt = 16'h0000;
    logic last_low = 1'b1;

    // four cycles high, four low: wider than the three-stage sync needs
    assign o_ext_irq_pin_a = (cnt_a > 4'h4);
    assign o_ext_irq_pin_b = (cnt_b > 4'h4);

    assign o_low_edges = edge_cnt;

    always @(posedge i_ref_clk) begin
        cnt_a <= i_fire_a ? 4'h8 : cnt_a - {3'h0, cnt_a != 4'h0};
        cnt_b <= i_fire_b ? 4'h8 : cnt_b - {3'h0, cnt_b != 4'h0};
        last_low <= i_low_output_pin;
        if (last_low !== i_low_output_pin) edge_cnt <= edge_cnt + 16'h0001;
    end
endmodule

`default_nettype wire
